// >>> logic/isrp_pkg.sv
// shared constants and types of the imu spi register port
package isrp_pkg;
  localparam int unsigned CLK_MHZ     = 100;
  localparam int unsigned FRAME_BITS  = 16;
  localparam int unsigned DRDY_NS     = 100;
  localparam int unsigned DRDY_CYCLES = (DRDY_NS * CLK_MHZ) / 1000;

  localparam logic [7:0]  PAGE_SENSOR = 8'h00;
  localparam logic [7:0]  PAGE_CTRL   = 8'h03;
  localparam logic [7:0]  PAGE_UNIT   = 8'h04;
  localparam logic [7:0]  PAGE_RESET  = 8'h00;

  localparam logic [6:0]  A_PAGE     = 7'h00;
  localparam logic [6:0]  A_TEMP     = 7'h0E;
  localparam logic [6:0]  A_RATE_XL  = 7'h10;
  localparam logic [6:0]  A_RATE_XH  = 7'h12;
  localparam logic [6:0]  A_RATE_YL  = 7'h14;
  localparam logic [6:0]  A_RATE_YH  = 7'h16;
  localparam logic [6:0]  A_RATE_ZL  = 7'h18;
  localparam logic [6:0]  A_RATE_ZH  = 7'h1A;
  localparam logic [6:0]  A_ACC_XL   = 7'h1C;
  localparam logic [6:0]  A_ACC_XH   = 7'h1E;
  localparam logic [6:0]  A_ACC_YL   = 7'h20;
  localparam logic [6:0]  A_ACC_YH   = 7'h22;
  localparam logic [6:0]  A_ACC_ZL   = 7'h24;
  localparam logic [6:0]  A_ACC_ZH   = 7'h26;
  localparam logic [6:0]  A_FLD_X    = 7'h28;
  localparam logic [6:0]  A_FLD_Y    = 7'h2A;
  localparam logic [6:0]  A_FLD_Z    = 7'h2C;
  localparam logic [6:0]  A_PRES_L   = 7'h2E;
  localparam logic [6:0]  A_PRES_H   = 7'h30;
  localparam logic [6:0]  A_PIN_FUNC = 7'h06;
  localparam logic [6:0]  A_GPIO     = 7'h08;
  localparam logic [6:0]  A_SERIAL   = 7'h20;

  localparam logic [15:0] PIN_FUNC_RESET = 16'h000D;
  localparam logic [15:0] GPIO_RESET     = 16'h0000;
  // arbitrary value, stands in for a per-unit serial number
  localparam logic [15:0] SERIAL_NUMBER  = 16'h5A5A;

  // request word fields, msb first on the wire
  localparam int unsigned REQ_WR_BIT = 15;
  localparam int unsigned REQ_A_MSB  = 14;
  localparam int unsigned REQ_A_LSB  = 8;

  typedef struct packed {
    logic [15:0] temp;
    logic [31:0] rate_x;
    logic [31:0] rate_y;
    logic [31:0] rate_z;
    logic [31:0] accel_x;
    logic [31:0] accel_y;
    logic [31:0] accel_z;
    logic [15:0] field_x;
    logic [15:0] field_y;
    logic [15:0] field_z;
    logic [31:0] pressure;
  } isrp_sample_t;

  typedef struct packed {
    logic [15:0] pin_func;
    logic [15:0] gpio;
  } isrp_ctrl_t;
endpackage : isrp_pkg

// >>> logic/isrp_top.sv
// spi slave register port of the inertial measurement unit
// Function
// - device is slave; host drives clock, select
// - mode 3, idle high, sample rising edge
// - read word: 0, address, eight ignored bits
// - read answer shifts out in next frame
// - pipelined full-duplex reads after a read
// - page 0 selected after reset
// - word 0x8000 writes zero to page select
// - sensor values loaded autonomously without commands
// - data ready pin high on new data
// - 0x1A00 reads z rate high, 0x1800 low
// - rate word pairs at 0x10 to 0x1A
// - field words at 0x28, 0x2A, 0x2C
// - pressure low 0x2E, high 0x30
// - page 3 pin function register, reset 0x000D
// - page 3 gpio control register at 0x08
module isrp_top (
  input  wire logic                  I_CLK,           // core clock, 100 MHz
  input  wire logic                  I_RESETN,        // async reset, active low
  input  wire logic                  I_SCLK,          // spi clock from host
  input  wire logic                  I_CS_N,          // spi select, active low
  input  wire logic                  I_MOSI,          // spi data in
  output logic                       O_MISO,          // spi data out
  output logic                       O_MISO_OE_N,     // low while driving miso
  input  wire logic                  I_SAMPLE_VALID,  // pulse: new sample set
  input  wire isrp_pkg::isrp_sample_t I_SAMPLE,       // calibrated sample set
  output logic                       O_DATA_READY_PIN, // high on fresh data
  output isrp_pkg::isrp_ctrl_t       O_CTRL           // page 3 control words
);

  logic                  sclk_s1, sclk_s2, sclk_d;
  logic                  cs_s1, cs_s2, cs_d;
  logic                  mosi_s1, mosi_s2;
  logic                  sclk_rise, sclk_fall, cs_fall, cs_rise, frame_ok;
  logic [4:0]            bit_cnt;
  logic [15:0]           rx;
  logic [15:0]           tx_shift;
  logic [15:0]           resp;
  logic [15:0]           next_resp;
  logic [7:0]            page;
  isrp_pkg::isrp_sample_t sample_q;
  isrp_pkg::isrp_ctrl_t   ctrl;
  logic [7:0]            drdy_cnt;
  logic                  wr_req;
  logic [6:0]            req_addr;
  logic [6:0]            word_addr;

  // pins are asynchronous to I_CLK
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      sclk_s1 <= 1'b1;
      sclk_s2 <= 1'b1;
      sclk_d  <= 1'b1;
      cs_s1   <= 1'b1;
      cs_s2   <= 1'b1;
      cs_d    <= 1'b1;
      mosi_s1 <= 1'b0;
      mosi_s2 <= 1'b0;
    end else begin
      sclk_s1 <= I_SCLK;
      sclk_s2 <= sclk_s1;
      sclk_d  <= sclk_s2;
      cs_s1   <= I_CS_N;
      cs_s2   <= cs_s1;
      cs_d    <= cs_s2;
      mosi_s1 <= I_MOSI;
      mosi_s2 <= mosi_s1;
    end
  end

  assign sclk_rise = sclk_s2 & ~sclk_d & ~cs_s2;
  assign sclk_fall = ~sclk_s2 & sclk_d & ~cs_s2;
  assign cs_fall   = ~cs_s2 & cs_d;
  assign cs_rise   = cs_s2 & ~cs_d;
  // frames of any other length are dropped whole
  assign frame_ok  = cs_rise && (bit_cnt == 5'(isrp_pkg::FRAME_BITS));
  assign wr_req    = rx[isrp_pkg::REQ_WR_BIT];
  assign req_addr  = rx[isrp_pkg::REQ_A_MSB:isrp_pkg::REQ_A_LSB];
  assign word_addr = {req_addr[6:1], 1'b0};

  // receive side: counter saturates so an overlong frame never looks valid
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      bit_cnt <= 5'h00;
      rx      <= 16'h0000;
    end else if (cs_fall) begin
      bit_cnt <= 5'h00;
    end else if (sclk_rise) begin
      rx <= {rx[14:0], mosi_s2};
      if (bit_cnt != 5'h1F) begin
        bit_cnt <= bit_cnt + 5'h01;
      end
    end
  end

  function automatic logic [15:0] reg_read(
    input logic [7:0]             pg,
    input logic [6:0]             a,
    input isrp_pkg::isrp_sample_t s,
    input isrp_pkg::isrp_ctrl_t   c
  );
    logic [15:0] v;
    v = 16'h0000;
    if (a == isrp_pkg::A_PAGE) begin
      v = {8'h00, pg};
    end else if (pg == isrp_pkg::PAGE_SENSOR) begin
      unique case (a)
        isrp_pkg::A_TEMP:    v = s.temp;
        isrp_pkg::A_RATE_XL: v = s.rate_x[15:0];
        isrp_pkg::A_RATE_XH: v = s.rate_x[31:16];
        isrp_pkg::A_RATE_YL: v = s.rate_y[15:0];
        isrp_pkg::A_RATE_YH: v = s.rate_y[31:16];
        isrp_pkg::A_RATE_ZL: v = s.rate_z[15:0];
        isrp_pkg::A_RATE_ZH: v = s.rate_z[31:16];
        isrp_pkg::A_ACC_XL:  v = s.accel_x[15:0];
        isrp_pkg::A_ACC_XH:  v = s.accel_x[31:16];
        isrp_pkg::A_ACC_YL:  v = s.accel_y[15:0];
        isrp_pkg::A_ACC_YH:  v = s.accel_y[31:16];
        isrp_pkg::A_ACC_ZL:  v = s.accel_z[15:0];
        isrp_pkg::A_ACC_ZH:  v = s.accel_z[31:16];
        isrp_pkg::A_FLD_X:   v = s.field_x;
        isrp_pkg::A_FLD_Y:   v = s.field_y;
        isrp_pkg::A_FLD_Z:   v = s.field_z;
        isrp_pkg::A_PRES_L:  v = s.pressure[15:0];
        isrp_pkg::A_PRES_H:  v = s.pressure[31:16];
        default:             v = 16'h0000;
      endcase
    end else if (pg == isrp_pkg::PAGE_CTRL) begin
      if (a == isrp_pkg::A_PIN_FUNC) begin
        v = c.pin_func;
      end else if (a == isrp_pkg::A_GPIO) begin
        v = c.gpio;
      end
    end else if (pg == isrp_pkg::PAGE_UNIT && a == isrp_pkg::A_SERIAL) begin
      v = isrp_pkg::SERIAL_NUMBER;
    end
    return v;
  endfunction : reg_read

  // answer is captured when the request frame closes, so it is stable
  // for the whole next frame even if new samples land meanwhile
  always_comb begin
    next_resp = resp;
    if (cs_rise) begin
      next_resp = 16'h0000;
      if (frame_ok && !wr_req) begin
        next_resp = reg_read(page, req_addr, sample_q, ctrl);
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      resp <= 16'h0000;
    end else begin
      resp <= next_resp;
    end
  end

  // transmit side: msb appears on the first falling clock edge
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      tx_shift    <= 16'h0000;
      O_MISO      <= 1'b0;
      O_MISO_OE_N <= 1'b1;
    end else if (cs_fall) begin
      tx_shift    <= resp;
      O_MISO_OE_N <= 1'b0;
    end else if (cs_rise) begin
      O_MISO      <= 1'b0;
      O_MISO_OE_N <= 1'b1;
    end else if (sclk_fall) begin
      O_MISO   <= tx_shift[15];
      tx_shift <= {tx_shift[14:0], 1'b0};
    end
  end

  // byte writes: even address low byte, odd address high byte
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      page <= isrp_pkg::PAGE_RESET;
    end else if (frame_ok && wr_req && req_addr == isrp_pkg::A_PAGE) begin
      page <= rx[7:0];
    end
  end

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      ctrl.pin_func <= isrp_pkg::PIN_FUNC_RESET;
      ctrl.gpio     <= isrp_pkg::GPIO_RESET;
    end else if (frame_ok && wr_req && page == isrp_pkg::PAGE_CTRL) begin
      if (word_addr == isrp_pkg::A_PIN_FUNC) begin
        if (req_addr[0]) begin
          ctrl.pin_func[15:8] <= rx[7:0];
        end else begin
          ctrl.pin_func[7:0] <= rx[7:0];
        end
      end else if (word_addr == isrp_pkg::A_GPIO) begin
        if (req_addr[0]) begin
          ctrl.gpio[15:8] <= rx[7:0];
        end else begin
          ctrl.gpio[7:0] <= rx[7:0];
        end
      end
    end
  end

  assign O_CTRL = ctrl;

  // sample registers take only the processing path, never spi writes
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      sample_q <= '0;
    end else if (I_SAMPLE_VALID) begin
      sample_q <= I_SAMPLE;
    end
  end

  // data ready is a fixed-width pulse; retriggers on every new set
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      drdy_cnt         <= 8'h00;
      O_DATA_READY_PIN <= 1'b0;
    end else if (I_SAMPLE_VALID) begin
      drdy_cnt         <= 8'(isrp_pkg::DRDY_CYCLES - 1);
      O_DATA_READY_PIN <= 1'b1;
    end else if (drdy_cnt != 8'h00) begin
      drdy_cnt <= drdy_cnt - 8'h01;
    end else begin
      O_DATA_READY_PIN <= 1'b0;
    end
  end

  // lets the pulse width be checked without a long repetition
  logic [7:0] drdy_len;

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      drdy_len <= 8'h00;
    end else if (I_SAMPLE_VALID || !O_DATA_READY_PIN) begin
      drdy_len <= 8'h00;
    end else if (drdy_len != 8'hFF) begin
      drdy_len <= drdy_len + 8'h01;
    end
  end

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESETN);

  AST_SHORT_FRAME: assert property (
    cs_rise && bit_cnt != 5'(isrp_pkg::FRAME_BITS) |=> resp == 16'h0000 && $stable(page)
  ) else $error("frame of wrong length was accepted");

  AST_WRITE_NO_ANSWER: assert property (
    frame_ok && wr_req |=> resp == 16'h0000
  ) else $error("write frame left a read answer");

  AST_PAGE_ZERO: assert property (
    frame_ok && rx == 16'h8000 |=> page == 8'h00
  ) else $error("0x8000 did not select page 0");

  AST_READ_Z_HIGH: assert property (
    frame_ok && rx == 16'h1A00 && page == 8'h00 |=> resp == $past(sample_q.rate_z[31:16])
  ) else $error("z rate high word read wrong");

  AST_READ_Z_LOW: assert property (
    frame_ok && rx == 16'h1800 && page == 8'h00 |=> resp == $past(sample_q.rate_z[15:0])
  ) else $error("z rate low word read wrong");

  AST_RX_MSB_FIRST: assert property (
    sclk_rise |=> rx[0] == $past(mosi_s2) && rx[15:1] == $past(rx[14:0])
  ) else $error("receive shift wrong");

  AST_TX_SHIFT: assert property (
    sclk_fall && !cs_fall && !cs_rise |=> O_MISO == $past(tx_shift[15]) && !O_MISO_OE_N
  ) else $error("miso bit not driven on falling edge");

  AST_TX_LOAD: assert property (
    cs_fall |=> tx_shift == $past(resp) && !O_MISO_OE_N
  ) else $error("answer not loaded at frame start");

  AST_RO_UNCHANGED: assert property (
    frame_ok && wr_req && !I_SAMPLE_VALID |=> $stable(sample_q)
  ) else $error("spi write changed sample data");

  AST_LOAD: assert property (
    I_SAMPLE_VALID |=> sample_q == $past(I_SAMPLE)
  ) else $error("sample set not loaded");

  AST_DRDY_PULSE: assert property (
    I_SAMPLE_VALID |=> O_DATA_READY_PIN [*8]
  ) else $error("data ready pulse too short");

  COV_READ: cover property (frame_ok && !wr_req ##[1:1000] frame_ok && !wr_req);
  COV_WRITE_PAGE3: cover property (frame_ok && rx == 16'h8003);
  COV_SHORT: cover property (cs_rise && bit_cnt != 5'h10);
  COV_DRDY: cover property ($fell(O_DATA_READY_PIN));
  COV_UNIT: cover property (frame_ok && !wr_req && page == isrp_pkg::PAGE_UNIT);

  AST_DRIVE_IN_FRAME: assert property (
    !cs_s2 && !cs_fall |-> !O_MISO_OE_N
  ) else $error("miso not driven inside a frame");

  AST_RELEASE_IDLE: assert property (
    cs_s2 && !cs_rise |-> O_MISO_OE_N && !O_MISO
  ) else $error("miso driven while deselected");

  AST_COUNT_CLEAR: assert property (
    cs_fall |=> bit_cnt == 5'h00
  ) else $error("bit count not cleared at frame start");

  AST_PAGE_WRITE: assert property (
    frame_ok && wr_req && req_addr == isrp_pkg::A_PAGE |=> page == $past(rx[7:0])
  ) else $error("page write lost");

  AST_PAGE_HOLD: assert property (
    !(frame_ok && wr_req && req_addr == isrp_pkg::A_PAGE) |=> $stable(page)
  ) else $error("page changed without a page write");

  AST_READ_PAGE: assert property (
    frame_ok && !wr_req && req_addr == isrp_pkg::A_PAGE |=> resp == {8'h00, $past(page)}
  ) else $error("page read back wrong");

  AST_CTRL_HOLD: assert property (
    !(frame_ok && wr_req && page == isrp_pkg::PAGE_CTRL) |=> $stable(ctrl)
  ) else $error("control word changed without a page 3 write");

  AST_PIN_FUNC_HIGH: assert property (
    frame_ok && wr_req && page == isrp_pkg::PAGE_CTRL && word_addr == isrp_pkg::A_PIN_FUNC
      && req_addr[0] |=> ctrl.pin_func == {$past(rx[7:0]), $past(ctrl.pin_func[7:0])}
  ) else $error("high byte write to pin function wrong");

  AST_READ_RATE_X: assert property (
    frame_ok && !wr_req && page == isrp_pkg::PAGE_SENSOR && req_addr == isrp_pkg::A_RATE_XL
      |=> resp == $past(sample_q.rate_x[15:0])
  ) else $error("x rate low word read wrong");

  AST_READ_ACCEL: assert property (
    frame_ok && !wr_req && page == isrp_pkg::PAGE_SENSOR && req_addr == isrp_pkg::A_ACC_ZH
      |=> resp == $past(sample_q.accel_z[31:16])
  ) else $error("z accel high word read wrong");

  AST_READ_FIELD: assert property (
    frame_ok && !wr_req && page == isrp_pkg::PAGE_SENSOR && req_addr == isrp_pkg::A_FLD_Y
      |=> resp == $past(sample_q.field_y)
  ) else $error("y field word read wrong");

  AST_READ_PRES: assert property (
    frame_ok && !wr_req && page == isrp_pkg::PAGE_SENSOR && req_addr == isrp_pkg::A_PRES_H
      |=> resp == $past(sample_q.pressure[31:16])
  ) else $error("pressure high word read wrong");

  AST_READ_PIN_FUNC: assert property (
    frame_ok && !wr_req && page == isrp_pkg::PAGE_CTRL && req_addr == isrp_pkg::A_PIN_FUNC
      |=> resp == $past(ctrl.pin_func)
  ) else $error("pin function word read wrong");

  AST_RESP_HOLD: assert property (
    !cs_rise |=> $stable(resp)
  ) else $error("answer word changed inside a frame");

  AST_DRDY_BOUND: assert property (
    O_DATA_READY_PIN |-> drdy_len < 8'(isrp_pkg::DRDY_CYCLES)
  ) else $error("data ready pulse too long");

  AST_DRDY_WIDTH: assert property (
    $fell(O_DATA_READY_PIN) |-> $past(drdy_len) == 8'(isrp_pkg::DRDY_CYCLES - 1)
  ) else $error("data ready pulse width wrong");

endmodule : isrp_top

// >>> verif/isrp_host_model.sv
// host side spi master model, mode 3, eight core cycles per half bit
module isrp_host_model (
  input  wire logic I_CLK,       // core clock
  input  wire logic i_miso,      // data from device
  input  wire logic i_miso_oe_n, // device drive enable, active low
  output logic      o_sclk,      // serial clock, idles high
  output logic      o_cs_n,      // select, active low
  output logic      o_mosi       // data to device
);
  timeunit 1ns;
  timeprecision 1ps;
  logic miso_last = 1'b0;
  logic miso_seen;
  // undriven line shows the inverse of its last value, never a lucky match
  always @(posedge I_CLK) begin
    if (!i_miso_oe_n) begin
      miso_last <= i_miso;
    end
  end
  assign miso_seen = i_miso_oe_n ? ~miso_last : i_miso;
  initial begin
    o_sclk = 1'b1;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
  end
  // 160 ns serial period, well under the clock ceiling
  task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
    rx = 16'h0000;
    @(posedge I_CLK);
    o_cs_n <= 1'b0;
    repeat (8) @(posedge I_CLK);
    for (int i = 0; i < nbits; i++) begin  // one clock per bit, nbits clocks; sixteen is a full frame
      o_sclk <= 1'b0;
      o_mosi <= tx[15 - i];
      repeat (8) @(posedge I_CLK);
      o_sclk <= 1'b1;
      rx = {rx[14:0], miso_seen};
      repeat (8) @(posedge I_CLK);
    end
    o_cs_n <= 1'b1;
    o_mosi <= ~o_mosi;
    repeat (8) @(posedge I_CLK);
  endtask : xfer
endmodule : isrp_host_model

// >>> verif/test_isrp_top.sv
// self-checking bench of the imu spi register port
module test_isrp_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   I_CLK;
  logic                   I_RESETN;
  logic                   I_SAMPLE_VALID;
  logic                   sclk;
  logic                   cs_n;
  logic                   mosi;
  logic                   miso;
  logic                   miso_oe_n;
  logic                   drdy;
  isrp_pkg::isrp_sample_t smp;
  isrp_pkg::isrp_ctrl_t   ctrl;
  logic [31:0]            seed = 32'h8A0CD439;
  logic [15:0]            rx;
  logic [15:0]            w;
  int                     n_fail = 0;
  int                     n_tests = 0;

  isrp_top dut (.I_CLK(I_CLK), .I_RESETN(I_RESETN), .I_SCLK(sclk), .I_CS_N(cs_n),
    .I_MOSI(mosi), .O_MISO(miso), .O_MISO_OE_N(miso_oe_n), .I_SAMPLE_VALID(I_SAMPLE_VALID),
    .I_SAMPLE(smp), .O_DATA_READY_PIN(drdy), .O_CTRL(ctrl));
  isrp_host_model host (.I_CLK(I_CLK), .i_miso(miso), .i_miso_oe_n(miso_oe_n),
    .o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic [15:0] exp_p0(input logic [6:0] a, input isrp_pkg::isrp_sample_t s);
    case (a)
      isrp_pkg::A_TEMP:    return s.temp;
      isrp_pkg::A_RATE_XL: return s.rate_x[15:0];
      isrp_pkg::A_RATE_XH: return s.rate_x[31:16];
      isrp_pkg::A_RATE_YL: return s.rate_y[15:0];
      isrp_pkg::A_RATE_YH: return s.rate_y[31:16];
      isrp_pkg::A_RATE_ZL: return s.rate_z[15:0];
      isrp_pkg::A_RATE_ZH: return s.rate_z[31:16];
      isrp_pkg::A_ACC_XL:  return s.accel_x[15:0];
      isrp_pkg::A_ACC_XH:  return s.accel_x[31:16];
      isrp_pkg::A_ACC_YL:  return s.accel_y[15:0];
      isrp_pkg::A_ACC_YH:  return s.accel_y[31:16];
      isrp_pkg::A_ACC_ZL:  return s.accel_z[15:0];
      isrp_pkg::A_ACC_ZH:  return s.accel_z[31:16];
      isrp_pkg::A_FLD_X:   return s.field_x;
      isrp_pkg::A_FLD_Y:   return s.field_y;
      isrp_pkg::A_FLD_Z:   return s.field_z;
      isrp_pkg::A_PRES_L:  return s.pressure[15:0];
      isrp_pkg::A_PRES_H:  return s.pressure[31:16];
      default:             return 16'h0000;
    endcase
  endfunction : exp_p0

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    I_CLK = 1'b0;
    forever #5 I_CLK = ~I_CLK;
  end

  initial begin
    repeat (60000) @(posedge I_CLK);
    n_fail++;
    $display("BAD t=%0t run did not complete", $time);
    tally_and_finish();
  end

  initial begin
    I_RESETN = 1'b0;
    I_SAMPLE_VALID = 1'b0;
    smp = '0;
    repeat (4) @(posedge I_CLK);
    I_RESETN <= 1'b1;
    repeat (4) @(posedge I_CLK);
    chk(ctrl, {16'h000D, 16'h0000});
    chk(drdy, 1'b0);
    for (int k = 0; k < 9; k++) smp[k*32 +: 32] <= rnd();
    I_SAMPLE_VALID <= 1'b1;
    @(posedge I_CLK);
    I_SAMPLE_VALID <= 1'b0;
    #1 chk(drdy, 1'b1);
    repeat (9) @(posedge I_CLK);
    #1 chk(drdy, 1'b1);
    @(posedge I_CLK);
    #1 chk(drdy, 1'b0);
    // no page selection beforehand: page 0 must be current
    host.xfer(16'h1A00, 16, rx);
    host.xfer(16'h1800, 16, rx);
    chk(rx, smp.rate_z[31:16]);
    for (int i = 0; i < 18; i++) begin
      host.xfer({1'b0, 7'(8'h0E + 2 * i), 8'(rnd())}, 16, rx);
      chk(rx, i == 0 ? smp.rate_z[15:0] : exp_p0(7'(8'h0E + 2 * (i - 1)), smp));
    end
    // write to a read-only word, then read it back untouched
    host.xfer({8'h90, 8'(rnd())}, 16, rx);
    chk(rx, smp.pressure[31:16]);
    host.xfer(16'h1000, 16, rx);
    chk(rx, 16'h0000);
    host.xfer(16'h0000, 16, rx);
    chk(rx, smp.rate_x[15:0]);
    w = 16'(rnd());
    host.xfer(16'h8003, 16, rx);
    host.xfer({8'h86, w[7:0]}, 16, rx);
    host.xfer({8'h87, w[15:8]}, 16, rx);
    host.xfer({8'h89, w[7:0]}, 16, rx);
    chk(ctrl, {w, w[7:0], 8'h00});
    host.xfer(16'h0600, 16, rx);
    host.xfer(16'h0000, 16, rx);
    chk(rx, w);
    host.xfer(16'h8000, 16, rx);
    chk(rx, 16'h0003);
    // a fifteen-clock page write must be dropped
    host.xfer(16'h8003, 15, rx);
    host.xfer(16'h1A00, 16, rx);
    chk(rx, 16'h0000);
    host.xfer(16'h0000, 16, rx);
    chk(rx, smp.rate_z[31:16]);
    // unit page: serial word, then an unmapped word reads zero
    host.xfer(16'h8004, 16, rx);
    chk(rx, 16'h0000);
    host.xfer(16'h2000, 16, rx);
    host.xfer(16'h1000, 16, rx);
    chk(rx, isrp_pkg::SERIAL_NUMBER);
    host.xfer(16'h8000, 16, rx);
    chk(rx, 16'h0000);
    // two sets back to back: the later one wins and the pulse restarts
    for (int j = 0; j < 2; j++) begin
      for (int k = 0; k < 9; k++) smp[k*32 +: 32] <= rnd();
      I_SAMPLE_VALID <= 1'b1;
      @(posedge I_CLK);
    end
    I_SAMPLE_VALID <= 1'b0;
    repeat (9) @(posedge I_CLK);
    #1 chk(drdy, 1'b1);
    @(posedge I_CLK);
    #1 chk(drdy, 1'b0);
    host.xfer(16'h0E00, 16, rx);
    chk(rx, 16'h0000);
    host.xfer(16'h2C00, 16, rx);
    chk(rx, smp.temp);
    host.xfer(16'h8003, 16, rx);
    chk(rx, smp.field_z);
    host.xfer({8'h88, w[15:8]}, 16, rx);
    chk(ctrl, {w, w[7:0], w[15:8]});
    // reset in mid-run with page 3 current: page 0 and defaults return
    I_RESETN <= 1'b0;
    repeat (4) @(posedge I_CLK);
    I_RESETN <= 1'b1;
    repeat (4) @(posedge I_CLK);
    chk(ctrl, {16'h000D, 16'h0000});
    chk(drdy, 1'b0);
    host.xfer(16'h0000, 16, rx);
    host.xfer(16'h0000, 16, rx);
    chk(rx, 16'h0000);
    tally_and_finish();
  end
endmodule : test_isrp_top
